// ---- core/irs_evt_xfer.sv ----
`timescale 1ns/1ps
// toggle crossing for an event with a word held stable behind it
module irs_evt_xfer #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic arst_n,
  input wire logic src_pulse,
  input wire logic [W-1:0] src_data,
  output logic dst_pulse,
  output logic [W-1:0] dst_data
);
  logic tog_reg;
  logic [W-1:0] hold_reg;
  logic tog_s;
  logic tog_d_reg;

  always_ff @(posedge src_clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_reg <= 1'b0;
      hold_reg <= '0;
    end else if (src_pulse) begin
      tog_reg <= ~tog_reg;
      hold_reg <= src_data;
    end
  end

  irs_sync #(.W(1), .RST_VAL(1'b0)) u_tog_sync (
    .clk(dst_clk),
    .arst_n(arst_n),
    .d(tog_reg),
    .q(tog_s)
  );

  // hold_reg is quiet for many cycles around each toggle
  always_ff @(posedge dst_clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_d_reg <= 1'b0;
      dst_pulse <= 1'b0;
      dst_data <= '0;
    end else begin
      tog_d_reg <= tog_s;
      dst_pulse <= tog_s ^ tog_d_reg;
      if (tog_s ^ tog_d_reg) begin
        dst_data <= hold_reg;
      end
    end
  end
endmodule

// ---- core/irs_pkg.sv ----
package irs_pkg;

  // fixed seven-bit target address, binary 0010010
  localparam logic [6:0] SLAVE_ADDR = 7'h12;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int WR_XFER_W = ADDR_W + DATA_W;
  // bits per byte on the wire, and index of the last transmitted bit
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [4:0] CNT_STEP = 5'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // fastest serial clock the link accepts, and the link sampling clock
  localparam int SCL_MAX_KHZ = 400;
  localparam int LINK_CLK_PS = 15000;
  localparam int SCL_HALF_NS = 1000000 / (2 * SCL_MAX_KHZ);
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * 1000) / LINK_CLK_PS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEV = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_REG = 4'b0011,
    ST_REG_ACK = 4'b0100,
    ST_WR = 4'b0101,
    ST_WR_ACK = 4'b0110,
    ST_RD = 4'b0111,
    ST_RD_ACK = 4'b1000,
    ST_SKIP = 4'b1001
  } irs_state_t;

endpackage

// ---- core/irs_slave.sv ----
`timescale 1ns/1ps
module irs_slave (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  irs_pkg::irs_state_t state_reg;
  irs_pkg::irs_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_next;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [4:0] cnt_reg;
  logic rw_reg;
  logic nak_reg;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic rx_state;
  logic byte_done;
  logic addr_hit;
  logic wr_req;
  logic rd_req;
  logic [4:0] reg_addr_byte;
  logic wr_evt;
  logic [12:0] wr_evt_data;
  logic rd_evt;
  logic [4:0] rd_evt_addr;
  logic rd_pend_reg;
  logic rep_pulse;
  logic [7:0] rep_data;

  // link side: sampled on link_clk, pins pass two flops first
  irs_sync #(.W(2), .RST_VAL(2'b11)) u_pin_sync (
    .clk(link_clk),
    .arst_n(arst_n),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // link_clk oversamples a 400 kHz bus many times per half period
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign rx_state = (state_reg == irs_pkg::ST_DEV) || (state_reg == irs_pkg::ST_REG) ||
                    (state_reg == irs_pkg::ST_WR);
  assign byte_done = rx_state && scl_fall && (bit_cnt_reg == irs_pkg::BYTE_BITS);
  assign addr_hit = (shift_reg[7:1] == irs_pkg::SLAVE_ADDR);
  assign reg_addr_byte = shift_reg[4:0];

  always_comb begin
    state_next = state_reg;
    bit_next = bit_cnt_reg;
    tx_next = tx_reg;
    if (stop_det) begin
      state_next = irs_pkg::ST_IDLE;
      bit_next = irs_pkg::BIT_CNT_RST;
    end else if (start_det) begin
      state_next = irs_pkg::ST_DEV;
      bit_next = irs_pkg::BIT_CNT_RST;
    end else begin
      if (rx_state && scl_rise) begin
        bit_next = bit_cnt_reg + 4'h1;
      end
      case (state_reg)
        irs_pkg::ST_DEV: begin
          if (byte_done) begin
            bit_next = irs_pkg::BIT_CNT_RST;
            state_next = addr_hit ? irs_pkg::ST_DEV_ACK : irs_pkg::ST_SKIP;
          end
        end
        irs_pkg::ST_REG: begin
          if (byte_done) begin
            bit_next = irs_pkg::BIT_CNT_RST;
            state_next = irs_pkg::ST_REG_ACK;
          end
        end
        irs_pkg::ST_WR: begin
          if (byte_done) begin
            bit_next = irs_pkg::BIT_CNT_RST;
            state_next = irs_pkg::ST_WR_ACK;
          end
        end
        irs_pkg::ST_DEV_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              state_next = irs_pkg::ST_RD;
              tx_next = rep_data;
            end else begin
              state_next = irs_pkg::ST_REG;
            end
          end
        end
        irs_pkg::ST_REG_ACK, irs_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            state_next = irs_pkg::ST_WR;
          end
        end
        irs_pkg::ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_reg == irs_pkg::TX_LAST_BIT) begin
              state_next = irs_pkg::ST_RD_ACK;
              bit_next = irs_pkg::BIT_CNT_RST;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              bit_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        irs_pkg::ST_RD_ACK: begin
          if (scl_fall) begin
            if (nak_reg) begin
              state_next = irs_pkg::ST_SKIP;
            end else begin
              state_next = irs_pkg::ST_RD;
              tx_next = rep_data;
            end
          end
        end
        irs_pkg::ST_IDLE, irs_pkg::ST_SKIP: begin
          state_next = state_reg;
        end
        default: begin
          state_next = irs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= irs_pkg::ST_IDLE;
      bit_cnt_reg <= irs_pkg::BIT_CNT_RST;
      tx_reg <= irs_pkg::BYTE_RST;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_next;
      tx_reg <= tx_next;
    end
  end

  // received bits, msb first, taken on the rising serial clock
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= irs_pkg::BYTE_RST;
      rw_reg <= 1'b0;
      nak_reg <= 1'b1;
    end else begin
      if (rx_state && scl_rise) begin
        shift_reg <= {shift_reg[6:0], sda_s};
      end
      if (state_reg == irs_pkg::ST_DEV && byte_done) begin
        rw_reg <= shift_reg[0];
      end
      if (state_reg == irs_pkg::ST_RD_ACK && scl_rise) begin
        nak_reg <= sda_s;
      end
    end
  end

  // address counter, untouched by a start condition
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= irs_pkg::CNT_RST;
    end else if (state_reg == irs_pkg::ST_REG && byte_done) begin
      cnt_reg <= reg_addr_byte;
    end else if (wr_req) begin
      cnt_reg <= cnt_reg + irs_pkg::CNT_STEP;
    end else if (state_reg == irs_pkg::ST_RD && scl_fall &&
                 bit_cnt_reg == irs_pkg::TX_LAST_BIT && !start_det && !stop_det) begin
      cnt_reg <= cnt_reg + irs_pkg::CNT_STEP;
    end
  end

  assign wr_req = (state_reg == irs_pkg::ST_WR) && byte_done;
  assign rd_req = ((state_reg == irs_pkg::ST_DEV) && byte_done && addr_hit && shift_reg[0]) ||
                  ((state_reg == irs_pkg::ST_RD_ACK) && scl_rise && !sda_s);

  // state only moves on a falling serial clock or a bus condition
  assign sda_oe_next = (state_next == irs_pkg::ST_DEV_ACK) ||
                       (state_next == irs_pkg::ST_REG_ACK) ||
                       (state_next == irs_pkg::ST_WR_ACK) ||
                       ((state_next == irs_pkg::ST_RD) && !tx_next[7]);

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= sda_oe_next;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign sda_o = 1'b0;

  irs_evt_xfer #(.W(irs_pkg::WR_XFER_W)) u_wr_xfer (
    .src_clk(link_clk),
    .dst_clk(clk),
    .arst_n(arst_n),
    .src_pulse(wr_req),
    .src_data({cnt_reg, shift_reg}),
    .dst_pulse(wr_evt),
    .dst_data(wr_evt_data)
  );

  irs_evt_xfer #(.W(irs_pkg::ADDR_W)) u_rd_xfer (
    .src_clk(link_clk),
    .dst_clk(clk),
    .arst_n(arst_n),
    .src_pulse(rd_req),
    .src_data(cnt_reg),
    .dst_pulse(rd_evt),
    .dst_data(rd_evt_addr)
  );

  irs_evt_xfer #(.W(irs_pkg::DATA_W)) u_rep_xfer (
    .src_clk(clk),
    .dst_clk(link_clk),
    .arst_n(arst_n),
    .src_pulse(rd_pend_reg),
    .src_data(reg_rdata),
    .dst_pulse(rep_pulse),
    .dst_data(rep_data)
  );

  // register side on clk: one-cycle strobes, read data taken next cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      rd_pend_reg <= 1'b0;
      reg_addr <= irs_pkg::CNT_RST;
      reg_wdata <= irs_pkg::BYTE_RST;
    end else begin
      reg_wr_en <= wr_evt;
      reg_rd_en <= rd_evt;
      rd_pend_reg <= reg_rd_en;
      if (wr_evt) begin
        reg_addr <= wr_evt_data[12:8];
        reg_wdata <= wr_evt_data[7:0];
      end else if (rd_evt) begin
        reg_addr <= rd_evt_addr;
      end
    end
  end

  AST_ACK_ON_MATCH: assert property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_DEV) && byte_done && addr_hit |=> sda_oe_reg [*2])
    else $error("no acknowledge after matching address");
  AST_SILENT_MISMATCH: assert property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_DEV) && byte_done && !addr_hit |=>
      (state_reg == irs_pkg::ST_SKIP) && !sda_oe_reg)
    else $error("drove bus for another target");
  AST_SDA_SCL_LOW: assert property (@(posedge link_clk) disable iff (!arst_n)
    $changed(sda_oe_reg) && !$past(start_det) && !$past(stop_det) |-> !$past(scl_s))
    else $error("sda changed while scl high");
  AST_START_RESTART: assert property (@(posedge link_clk) disable iff (!arst_n)
    start_det |=> (state_reg == irs_pkg::ST_DEV) && (bit_cnt_reg == 4'h0) && $stable(cnt_reg))
    else $error("start did not restart address phase");
  AST_STOP_IDLE: assert property (@(posedge link_clk) disable iff (!arst_n)
    stop_det |=> (state_reg == irs_pkg::ST_IDLE) && !sda_oe_reg)
    else $error("stop did not return to idle");
  AST_CNT_LOAD: assert property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_REG) && byte_done |=> cnt_reg == $past(reg_addr_byte))
    else $error("register address not loaded");
  AST_WR_INC: assert property (@(posedge link_clk) disable iff (!arst_n)
    wr_req |=> (cnt_reg == $past(cnt_reg) + 5'h01) && (state_reg == irs_pkg::ST_WR_ACK))
    else $error("write did not advance counter");
  AST_RD_INC: assert property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_RD) && scl_fall && (bit_cnt_reg == 4'h7) |=>
      (cnt_reg == $past(cnt_reg) + 5'h01) && (state_reg == irs_pkg::ST_RD_ACK) && !sda_oe_reg)
    else $error("read byte end wrong");
  AST_NAK_RELEASE: assert property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_RD_ACK) && nak_reg && scl_fall |=>
      (state_reg == irs_pkg::ST_SKIP) && !sda_oe_reg)
    else $error("kept driving after missing acknowledge");
  AST_READ_DIR: assert property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_DEV_ACK) && scl_fall && rw_reg |=>
      (state_reg == irs_pkg::ST_RD) && (sda_oe_reg == !$past(rep_data[7])))
    else $error("read request not served");
  AST_RD_STROBE: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd_en |=> rd_pend_reg ##0 !reg_rd_en)
    else $error("read strobe not single cycle");

  COV_WRAP: cover property (@(posedge link_clk) disable iff (!arst_n)
    wr_req && (cnt_reg == 5'h1f));
  COV_RANDOM_READ: cover property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_REG_ACK) ##[1:1000] start_det ##1
      (state_reg == irs_pkg::ST_DEV));
  COV_BURST_READ: cover property (@(posedge link_clk) disable iff (!arst_n)
    (state_reg == irs_pkg::ST_RD_ACK) && !nak_reg && scl_fall);
  COV_REPLY: cover property (@(posedge link_clk) disable iff (!arst_n) rep_pulse);
endmodule

// ---- core/irs_sync.sv ----
`timescale 1ns/1ps
module irs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ---- tb/i2c_register_access_slave_bench.sv ----
`timescale 1ns/1ps
module i2c_register_access_slave_bench;
  logic clk, arst_n, link_clk, scl, sda_low, sda_w;
  logic sda_o, sda_oe, reg_wr_en, reg_rd_en, oe_d, scl_d;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [7:0] mem [32];
  int err_count, samples_checked;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // open-drain wire with pull-up
  assign sda_w = ~(sda_oe & ~sda_o) & ~sda_low;
  irs_slave DUT (.clk(clk), .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  irs_host u_host (.link_clk(link_clk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
  // register store behind the strobes, answer one edge after the read strobe
  always @(posedge clk) begin
    if (reg_rd_en === 1'b1) reg_rdata <= mem[reg_addr];
    if (reg_wr_en === 1'b1) mem[reg_addr] <= reg_wdata;
  end
  always @(negedge link_clk) begin
    scl_d <= scl;
    oe_d <= sda_oe;
    if (arst_n && scl && scl_d) chk1("sda_oe_in_scl_high", oe_d, sda_oe);
  end
  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d, input logic exp_ack, input string what);
    logic a;
    u_host.send_byte(d, a);
    chk1(what, exp_ack, a);
  endtask
  // preloaded contents are a0h xor address
  task automatic rx(input logic ack, input logic [4:0] a);
    logic [7:0] d;
    u_host.recv_byte(ack, d);
    chk8("read_byte", 8'ha0 ^ {3'h0, a}, d);
  endtask
  task automatic t_idle_values();
    chk1("sda_oe", 1'b0, sda_oe);
    chk1("strobes", 1'b0, reg_wr_en | reg_rd_en);
    chk8("reg_addr", 8'h00, {3'h0, reg_addr});
    chk8("reg_wdata", 8'h00, reg_wdata);
    $display("test idle_values done");
  endtask
  task automatic t_write_burst();
    u_host.start();
    tx(8'h24, 1'b1, "ack_addr_write");
    tx(8'h11, 1'b1, "ack_reg_addr");
    tx(8'h5a, 1'b1, "ack_data");
    tx(8'h0c, 1'b1, "ack_data");
    tx(8'h35, 1'b1, "ack_data");
    u_host.stop();
    chk8("mem_11", 8'h5a, mem[5'h11]);
    chk8("mem_12", 8'h0c, mem[5'h12]);
    chk8("mem_13", 8'h35, mem[5'h13]);
    $display("test write_burst done");
  endtask
  task automatic t_current_read();
    u_host.start();
    tx(8'h25, 1'b1, "ack_addr_read");
    rx(1'b1, 5'h14);
    rx(1'b0, 5'h15);
    u_host.stop();
    chk1("sda_oe_after_nak", 1'b0, sda_oe);
    $display("test current_read done");
  endtask
  task automatic t_random_read();
    u_host.start();
    tx(8'h24, 1'b1, "ack_addr_write");
    tx(8'h1f, 1'b1, "ack_reg_addr");
    u_host.start();
    tx(8'h25, 1'b1, "ack_addr_read");
    rx(1'b1, 5'h1f);
    rx(1'b1, 5'h00);
    rx(1'b0, 5'h01);
    u_host.stop();
    $display("test random_read done");
  endtask
  task automatic t_wrong_addr();
    u_host.start();
    tx(8'h26, 1'b0, "nak_other_addr");
    tx(8'h02, 1'b0, "silent_after_miss");
    tx(8'h77, 1'b0, "silent_after_miss");
    u_host.stop();
    chk8("mem_02", 8'ha2, mem[5'h02]);
    $display("test wrong_addr done");
  endtask
  task automatic t_abort();
    logic s;
    u_host.start();
    tx(8'h24, 1'b1, "ack_addr_write");
    tx(8'h05, 1'b1, "ack_reg_addr");
    repeat (3) u_host.clk_bit(1'b0, s);
    u_host.start();
    tx(8'h25, 1'b1, "ack_after_restart");
    rx(1'b0, 5'h05);
    u_host.stop();
    chk8("mem_05", 8'ha5, mem[5'h05]);
    u_host.start();
    tx(8'h25, 1'b1, "ack_addr_read");
    rx(1'b0, 5'h06);
    u_host.stop();
    $display("test abort done");
  endtask
  task automatic t_reset_mid();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk8("reg_addr_in_reset", 8'h00, {3'h0, reg_addr});
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    u_host.start();
    tx(8'h25, 1'b1, "ack_addr_read");
    rx(1'b0, 5'h00);
    u_host.stop();
    $display("test reset_mid done");
  endtask
  initial begin
    arst_n = 1'b0;
    reg_rdata = 8'h00;
    err_count = 0;
    samples_checked = 0;
    oe_d = 1'b0;
    scl_d = 1'b1;
    for (int i = 0; i < 32; i++) mem[i] = 8'ha0 ^ i[7:0];
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_idle_values();
    t_write_burst();
    t_current_read();
    t_random_read();
    t_wrong_addr();
    t_abort();
    t_reset_mid();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    stop_test();
  end
endmodule

// ---- tb/irs_host.sv ----
`timescale 1ns/1ps
module irs_host (
  input wire logic link_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_low
);
  // quarter of an scl period, rounded up to stay at or under 400 kHz
  localparam int Q = irs_pkg::SCL_HALF_CYC / 2 + 1;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // every level held at least one quarter period
  task automatic start();
    sda_low <= 1'b0;
    wt(Q);
    scl <= 1'b1;
    wt(2 * Q);
    sda_low <= 1'b1; // fall while high
    wt(2 * Q);
    scl <= 1'b0;
    wt(Q);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wt(Q);
    scl <= 1'b1;
    wt(2 * Q);
    sda_low <= 1'b0; // rise while high
    wt(2 * Q);
  endtask
  // data moves only in the low half
  task automatic clk_bit(input logic b, output logic s);
    sda_low <= ~b;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    @(negedge link_clk);
    s = sda_w;
    wt(Q);
    scl <= 1'b0;
    wt(Q);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s); // released during the ninth clock
    ack = ~s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~ack, s);
  endtask
endmodule
